// ===== core/cids_bus_seq.sv
// bus cycle sequencer for immediate and direct addressing modes
// the execution unit holds startReq until startAck; memory answers reads in the same cycle
`timescale 1ns/1ns
`default_nettype none
module cids_bus_seq
	import cids_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// execution unit request
	input wire logic startReq,
	input var cids_class_type startClass,
	input wire logic [ADDR_W-1:0] opAddr,
	input wire logic [DATA_W-1:0] accIn,
	output logic startAck,
	// execution unit results
	output logic [DATA_W-1:0] opcodeFirst,
	output logic [DATA_W-1:0] opcodeSecond,
	output logic [2*DATA_W-1:0] operandWord,
	output logic instrDone,
	// memory bus
	output logic [ADDR_W-1:0] busAddr,
	output logic busRw,
	output logic [DATA_W-1:0] busDataOut,
	output logic busDataOutEn,
	input wire logic [DATA_W-1:0] busDataIn
);
	cids_state_type st_r;
	cids_state_type st_nxt;
	cids_kind_type curKind;
	cids_kind_type nextKind;
	logic curLast;
	logic nextLast;
	logic [STEP_W-1:0] nextStep;
	logic [DATA_W-1:0] zpNext;
	logic startTaken;

	assign nextStep = st_r.step + FIRST_STEP;

	cids_step_plan u_cur_plan (
		.cls(st_r.cls),
		.step(st_r.step),
		.kind(curKind),
		.last(curLast)
	);

	cids_step_plan u_next_plan (
		.cls(st_r.cls),
		.step(nextStep),
		.kind(nextKind),
		.last(nextLast)
	);

	assign startAck = (st_r.phase == PH_IDLE);
	assign startTaken = startReq && startAck;
	// zero-page low byte arrives on the same edge that launches the operand cycle
	assign zpNext = (curKind == K_ZPADDR) ? busDataIn : st_r.zp;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.res.done = 1'b0;
		unique case (st_r.phase)
			PH_IDLE:
			begin
				if (startReq)
				begin
					st_nxt.phase = PH_RUN;
					st_nxt.step = FIRST_STEP;
					st_nxt.cls = startClass;
					st_nxt.base = opAddr;
					st_nxt.acc = accIn;
					st_nxt.bus.addr = opAddr;
					st_nxt.bus.rw = 1'b1;
					st_nxt.bus.dataOutEn = 1'b0;
					st_nxt.res.opcodeSecond = 8'h00;
					st_nxt.res.operand = 16'h0000;
				end
			end
			PH_RUN:
			begin
				unique case (curKind)
					K_OPC1: st_nxt.res.opcodeFirst = busDataIn;
					K_OPC2: st_nxt.res.opcodeSecond = busDataIn;
					K_OPH: st_nxt.res.operand[2*DATA_W-1:DATA_W] = busDataIn;
					K_OPL: st_nxt.res.operand[DATA_W-1:0] = busDataIn;
					K_OP8: st_nxt.res.operand = {ZERO_PAGE_HI, busDataIn};
					K_ZPADDR: st_nxt.zp = busDataIn;
					K_ZPDATA: st_nxt.res.operand = {ZERO_PAGE_HI, busDataIn};
					K_ZPSTORE, K_DUMMY:
					begin
						// dummy-read data is discarded on purpose
						st_nxt.zp = st_r.zp;
					end
					default:
					begin
						st_nxt.zp = st_r.zp;
					end
				endcase
				if (curLast)
				begin
					st_nxt.phase = PH_IDLE;
					st_nxt.res.done = 1'b1;
					st_nxt.bus.addr = DUMMY_ADDR;
					st_nxt.bus.rw = 1'b1;
					st_nxt.bus.dataOutEn = 1'b0;
				end
				else
				begin
					st_nxt.step = nextStep;
					st_nxt.bus.rw = (nextKind != K_ZPSTORE);
					st_nxt.bus.dataOutEn = (nextKind == K_ZPSTORE);
					st_nxt.bus.dataOut = st_r.acc;
					if (nextKind == K_ZPDATA || nextKind == K_ZPSTORE)
						st_nxt.bus.addr = {ZERO_PAGE_HI, zpNext};
					else if (nextKind == K_DUMMY)
						st_nxt.bus.addr = DUMMY_ADDR;
					else
						st_nxt.bus.addr = st_r.base + ADDR_W'(st_r.step);
				end
			end
			default:
			begin
				st_nxt = STATE_RESET;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			st_r <= STATE_RESET;
		else
			st_r <= st_nxt;
	end

	assign busAddr = st_r.bus.addr;
	assign busRw = st_r.bus.rw;
	assign busDataOut = st_r.bus.dataOut;
	assign busDataOutEn = st_r.bus.dataOutEn;
	assign opcodeFirst = st_r.res.opcodeFirst;
	assign opcodeSecond = st_r.res.opcodeSecond;
	assign operandWord = st_r.res.operand;
	assign instrDone = st_r.res.done;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_imm16_load_addr: assert property (
		startTaken && startClass == CL_IMM16_LOAD |=> busRw && busAddr == $past(opAddr)
		##1 busRw && busAddr == $past(opAddr, 2) + 16'h0001
		##1 busRw && busAddr == $past(opAddr, 3) + 16'h0002 ##1 instrDone)
		else $error("16-bit immediate load address sequence wrong");

	a_imm16_byte_order: assert property (
		startTaken && startClass == CL_IMM16_LOAD |=> ##3 instrDone
		&& operandWord == {$past(busDataIn, 2), $past(busDataIn, 1)} && opcodeFirst == $past(busDataIn, 3))
		else $error("16-bit immediate operand byte order wrong");

	a_arith_dummy_read: assert property (
		startTaken && startClass == CL_IMM16_ARITH |=> !instrDone [*3]
		##1 busAddr == DUMMY_ADDR && busRw && !instrDone
		##1 instrDone && operandWord[7:0] == $past(busDataIn, 2))
		else $error("immediate arithmetic dummy cycle wrong");

	a_prefix_load_seq: assert property (
		startTaken && startClass == CL_PFX_LOAD |=> !instrDone [*4]
		##1 instrDone && opcodeFirst == $past(busDataIn, 4) && opcodeSecond == $past(busDataIn, 3))
		else $error("prefixed load sequence wrong");

	a_prefix_cmp_seq: assert property (
		startTaken && startClass == CL_PFX_CMP |=> ##2 busAddr == $past(opAddr, 3) + 16'h0002
		##1 busAddr == $past(opAddr, 4) + 16'h0003 ##1 busAddr == DUMMY_ADDR && busRw ##1 instrDone)
		else $error("prefixed compare sequence wrong");

	a_direct_zero_page: assert property (
		startTaken && startClass == CL_DIR_READ |=> ##1 busAddr == $past(opAddr, 2) + 16'h0001
		##1 busRw && busAddr == {ZERO_PAGE_HI, $past(busDataIn)} ##1 instrDone
		&& operandWord == {ZERO_PAGE_HI, $past(busDataIn)})
		else $error("direct read zero-page cycle wrong");

	a_direct_store_drive: assert property (
		startTaken && startClass == CL_DIR_STORE |=> busRw && !busDataOutEn [*2]
		##1 !busRw && busDataOutEn && busDataOut == $past(accIn, 3) ##1 instrDone && !busDataOutEn)
		else $error("direct store cycle wrong");

	a_read_not_driven: assert property (
		busRw |-> !busDataOutEn)
		else $error("data driven during a read cycle");

	a_imm8_two_cycles: assert property (
		startTaken && startClass == CL_IMM8 |=> busRw && busAddr == $past(opAddr)
		##1 busRw && busAddr == $past(opAddr, 2) + 16'h0001
		##1 instrDone && operandWord == {ZERO_PAGE_HI, $past(busDataIn)})
		else $error("8-bit immediate sequence wrong");

	a_idle_bus_parked: assert property (
		startAck |-> busRw && !busDataOutEn && busAddr == DUMMY_ADDR)
		else $error("idle bus not parked on a dummy read");

	a_busy_keeps_base: assert property (
		rst_b && !startAck |=> $stable(st_r.base) && $stable(st_r.acc))
		else $error("request taken while an instruction runs");

	a_prefix_load_addr: assert property (
		startTaken && startClass == CL_PFX_LOAD |=> busRw && busAddr == $past(opAddr)
		##1 busRw && busAddr == $past(opAddr, 2) + 16'h0001
		##1 busRw && busAddr == $past(opAddr, 3) + 16'h0002
		##1 busRw && busAddr == $past(opAddr, 4) + 16'h0003
		##1 instrDone && operandWord == {$past(busDataIn, 2), $past(busDataIn, 1)})
		else $error("prefixed load address sequence wrong");

	a_prefix_cmp_bytes: assert property (
		startTaken && startClass == CL_PFX_CMP |=> busRw [*5] ##1 instrDone
		&& operandWord == {$past(busDataIn, 3), $past(busDataIn, 2)} && opcodeSecond == $past(busDataIn, 4))
		else $error("prefixed compare byte capture wrong");

	a_arith_addr_seq: assert property (
		startTaken && startClass == CL_IMM16_ARITH |=> busRw && busAddr == $past(opAddr)
		##1 busRw && busAddr == $past(opAddr, 2) + 16'h0001
		##1 busRw && busAddr == $past(opAddr, 3) + 16'h0002 ##2 instrDone
		&& operandWord[15:8] == $past(busDataIn, 3))
		else $error("immediate arithmetic operand cycles wrong");

	a_store_addr_seq: assert property (
		startTaken && startClass == CL_DIR_STORE |=> busAddr == $past(opAddr)
		##1 busAddr == $past(opAddr, 2) + 16'h0001
		##1 busAddr == {ZERO_PAGE_HI, $past(busDataIn)})
		else $error("direct store address sequence wrong");
endmodule
`default_nettype wire

// ===== core/cids_pkg.sv
// constants, classes and carrier structs for the immediate/direct bus sequencer
// assumes one bus cycle per clk; the execution unit names the instruction class
package cids_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int STEP_W = 3;
	localparam logic [ADDR_W-1:0] DUMMY_ADDR = 16'hFFFF;
	localparam logic [DATA_W-1:0] ZERO_PAGE_HI = 8'h00;
	localparam logic [STEP_W-1:0] FIRST_STEP = 3'h1;
	localparam logic [STEP_W-1:0] CYC_IMM8 = 3'h2;
	localparam logic [STEP_W-1:0] CYC_IMM16_LOAD = 3'h3;
	localparam logic [STEP_W-1:0] CYC_IMM16_ARITH = 3'h4;
	localparam logic [STEP_W-1:0] CYC_PFX_LOAD = 3'h4;
	localparam logic [STEP_W-1:0] CYC_PFX_CMP = 3'h5;
	localparam logic [STEP_W-1:0] CYC_DIRECT = 3'h3;

	typedef enum logic [2:0] {
		CL_IMM8 = 3'h0,
		CL_IMM16_LOAD = 3'h1,
		CL_IMM16_ARITH = 3'h2,
		CL_PFX_LOAD = 3'h3,
		CL_PFX_CMP = 3'h4,
		CL_DIR_READ = 3'h5,
		CL_DIR_STORE = 3'h6
	} cids_class_type;

	typedef enum logic [3:0] {
		K_OPC1 = 4'h0,
		K_OPC2 = 4'h1,
		K_OPH = 4'h2,
		K_OPL = 4'h3,
		K_OP8 = 4'h4,
		K_ZPADDR = 4'h5,
		K_ZPDATA = 4'h6,
		K_ZPSTORE = 4'h7,
		K_DUMMY = 4'h8
	} cids_kind_type;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b01,
		PH_RUN = 2'b10
	} cids_phase_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic rw;
		logic [DATA_W-1:0] dataOut;
		logic dataOutEn;
	} cids_bus_type;

	typedef struct packed {
		logic [DATA_W-1:0] opcodeFirst;
		logic [DATA_W-1:0] opcodeSecond;
		logic [2*DATA_W-1:0] operand;
		logic done;
	} cids_result_type;

	typedef struct packed {
		cids_phase_type phase;
		logic [STEP_W-1:0] step;
		cids_class_type cls;
		logic [ADDR_W-1:0] base;
		logic [DATA_W-1:0] zp;
		logic [DATA_W-1:0] acc;
		cids_bus_type bus;
		cids_result_type res;
	} cids_state_type;

	localparam cids_state_type STATE_RESET = '{
		phase: PH_IDLE,
		step: FIRST_STEP,
		cls: CL_IMM8,
		base: DUMMY_ADDR,
		zp: ZERO_PAGE_HI,
		acc: 8'h00,
		bus: '{addr: DUMMY_ADDR, rw: 1'b1, dataOut: 8'h00, dataOutEn: 1'b0},
		res: '{opcodeFirst: 8'h00, opcodeSecond: 8'h00, operand: 16'h0000, done: 1'b0}
	};
endpackage

// ===== core/cids_step_plan.sv
// per-step bus cycle kind for each instruction class
// pure combinational; steps count from one
`timescale 1ns/1ns
`default_nettype none
module cids_step_plan
	import cids_pkg::*;
(
	// selection
	input var cids_class_type cls,
	input wire logic [STEP_W-1:0] step,
	// plan
	output var cids_kind_type kind,
	output logic last
);
	logic [STEP_W-1:0] cycles;

	always_comb
	begin
		kind = K_DUMMY;
		cycles = CYC_DIRECT;
		unique case (cls)
			CL_IMM8:
			begin
				cycles = CYC_IMM8;
				if (step == 3'h2) kind = K_OP8;
			end
			CL_IMM16_LOAD, CL_IMM16_ARITH:
			begin
				cycles = (cls == CL_IMM16_LOAD) ? CYC_IMM16_LOAD : CYC_IMM16_ARITH;
				if (step == 3'h2) kind = K_OPH;
				if (step == 3'h3) kind = K_OPL;
			end
			CL_PFX_LOAD, CL_PFX_CMP:
			begin
				cycles = (cls == CL_PFX_LOAD) ? CYC_PFX_LOAD : CYC_PFX_CMP;
				if (step == 3'h2) kind = K_OPC2;
				if (step == 3'h3) kind = K_OPH;
				if (step == 3'h4) kind = K_OPL;
			end
			CL_DIR_READ, CL_DIR_STORE:
			begin
				if (step == 3'h2) kind = K_ZPADDR;
				if (step == 3'h3) kind = (cls == CL_DIR_STORE) ? K_ZPSTORE : K_ZPDATA;
			end
			default:
			begin
				cycles = FIRST_STEP;
			end
		endcase
		if (step == FIRST_STEP) kind = K_OPC1;
		last = (step >= cycles);
	end
endmodule
`default_nettype wire

// ===== test/cids_mem_model.sv
// memory model that answers every read within the same bus cycle
// assumes the sequencer drives the bus from registers, one step per clk
`timescale 1ns/1ns
`default_nettype none
module cids_mem_model
	import cids_pkg::*;
(
	// clock
	input wire logic clk,
	// bus from the sequencer
	input wire logic [ADDR_W-1:0] busAddr,
	input wire logic busRw,
	input wire logic [DATA_W-1:0] busDataOut,
	input wire logic busDataOutEn,
	output logic [DATA_W-1:0] busDataIn,
	// last store seen
	output logic [ADDR_W-1:0] wrAddr,
	output logic [DATA_W-1:0] wrData
);
	logic [DATA_W-1:0] lastRead;

	function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction

	// a released bus shows the inverse of the last read, so stale data cannot pass
	always_comb
		busDataIn = busRw ? pat(busAddr) : ~lastRead;

	always_ff @(posedge clk)
	begin
		if (busRw)
			lastRead <= pat(busAddr);
		if (!busRw && busDataOutEn)
		begin
			wrAddr <= busAddr;
			wrData <= busDataOut;
		end
	end
endmodule
`default_nettype wire

// ===== test/test_cids_bus_seq.sv
// self-checking bench for the immediate/direct bus sequencer
// assumes the memory model fills memory with the same pattern as pat below
`timescale 1ns/1ns
`default_nettype none
module test_cids_bus_seq
	import cids_pkg::*;
();
	logic clk = 1'b0;
	logic rst_b, startReq, startAck, instrDone, busRw, busDataOutEn;
	cids_class_type startClass;
	logic [15:0] opAddr, operandWord, busAddr, wrAddr;
	logic [7:0] accIn, opcodeFirst, opcodeSecond, busDataOut, busDataIn, wrData;
	int miscompares = 0;
	int testsRun = 0;

	cids_bus_seq DUT (.clk(clk), .rst_b(rst_b), .startReq(startReq), .startClass(startClass), .opAddr(opAddr),
		.accIn(accIn), .startAck(startAck), .opcodeFirst(opcodeFirst), .opcodeSecond(opcodeSecond),
		.operandWord(operandWord), .instrDone(instrDone), .busAddr(busAddr), .busRw(busRw),
		.busDataOut(busDataOut), .busDataOutEn(busDataOutEn), .busDataIn(busDataIn));
	cids_mem_model mem (.clk(clk), .busAddr(busAddr), .busRw(busRw), .busDataOut(busDataOut),
		.busDataOutEn(busDataOutEn), .busDataIn(busDataIn), .wrAddr(wrAddr), .wrData(wrData));

	always #25 clk = ~clk;

	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction

	task automatic endOfTest;
		$display("comparisons %0d mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// waits for the sequencer to go idle; the request is dropped on the taking edge
	task automatic start(input cids_class_type c, input logic [15:0] a, input logic [7:0] acc);
		int i;
		i = 0;
		@(posedge clk);
		startReq <= 1'b1;
		startClass <= c;
		opAddr <= a;
		accIn <= acc;
		@(negedge clk);
		while (startAck !== 1'b1 && i < 20)
		begin
			@(negedge clk);
			i++;
		end
		if (startAck !== 1'b1)
		begin
			miscompares++;
			endOfTest();
		end
		@(posedge clk);
		startReq <= 1'b0;
	endtask

	task automatic busCyc(input logic [15:0] a, input logic rw);
		@(negedge clk);
		chk(busAddr, a);
		chk({13'h0000, busRw, busDataOutEn, startAck}, {13'h0000, rw, ~rw, 1'b0});
	endtask

	task automatic doneChk(input logic [15:0] opnd, input logic [7:0] o1, input logic [7:0] o2);
		@(negedge clk);
		chk({13'h0000, instrDone, busRw, startAck}, 16'h0007);
		chk(busAddr, 16'hFFFF);
		chk(operandWord, opnd);
		chk({opcodeFirst, opcodeSecond}, {o1, o2});
	endtask

	task automatic testImm16Load;
		start(CL_IMM16_LOAD, 16'hFFFE, 8'h00);
		busCyc(16'hFFFE, 1'b1);
		busCyc(16'hFFFF, 1'b1);
		busCyc(16'h0000, 1'b1);
		doneChk({pat(16'hFFFF), pat(16'h0000)}, pat(16'hFFFE), 8'h00);
		$display("imm16 load done");
	endtask

	task automatic testImm16Arith;
		start(CL_IMM16_ARITH, 16'h2000, 8'h00);
		busCyc(16'h2000, 1'b1);
		busCyc(16'h2001, 1'b1);
		busCyc(16'h2002, 1'b1);
		busCyc(16'hFFFF, 1'b1);
		doneChk({pat(16'h2001), pat(16'h2002)}, pat(16'h2000), 8'h00);
		$display("imm16 arith done");
	endtask

	task automatic testPfx(input cids_class_type c, input int n);
		int k;
		start(c, 16'h3000, 8'h00);
		for (k = 0; k < 4; k++)
			busCyc(16'h3000 + 16'(k), 1'b1);
		if (n == 5)
			busCyc(16'hFFFF, 1'b1);
		doneChk({pat(16'h3002), pat(16'h3003)}, pat(16'h3000), pat(16'h3001));
		$display("prefixed class done");
	endtask

	task automatic testImm8;
		start(CL_IMM8, 16'h1234, 8'h00);
		busCyc(16'h1234, 1'b1);
		busCyc(16'h1235, 1'b1);
		doneChk({8'h00, pat(16'h1235)}, pat(16'h1234), 8'h00);
		$display("imm8 done");
	endtask

	task automatic testDirect;
		logic [15:0] zr;
		logic [15:0] zs;
		zr = {8'h00, pat(16'h5001)};
		zs = {8'h00, pat(16'h6001)};
		start(CL_DIR_READ, 16'h5000, 8'h00);
		busCyc(16'h5000, 1'b1);
		busCyc(16'h5001, 1'b1);
		busCyc(zr, 1'b1);
		doneChk({8'h00, pat(zr)}, pat(16'h5000), 8'h00);
		start(CL_DIR_STORE, 16'h6000, 8'hC3);
		busCyc(16'h6000, 1'b1);
		busCyc(16'h6001, 1'b1);
		busCyc(zs, 1'b0);
		chk({8'h00, busDataOut}, 16'h00C3);
		doneChk(16'h0000, pat(16'h6000), 8'h00);
		chk(wrAddr, zs);
		chk({8'h00, wrData}, 16'h00C3);
		$display("direct done");
	endtask

	// a request raised while busy must wait; the running instruction keeps its own address
	task automatic testRefused;
		start(CL_IMM8, 16'h8000, 8'h00);
		busCyc(16'h8000, 1'b1);
		@(posedge clk);
		startReq <= 1'b1;
		startClass <= CL_IMM16_ARITH;
		opAddr <= 16'h9000;
		busCyc(16'h8001, 1'b1);
		doneChk({8'h00, pat(16'h8001)}, pat(16'h8000), 8'h00);
		@(posedge clk);
		startReq <= 1'b0;
		busCyc(16'h9000, 1'b1);
		busCyc(16'h9001, 1'b1);
		busCyc(16'h9002, 1'b1);
		busCyc(16'hFFFF, 1'b1);
		doneChk({pat(16'h9001), pat(16'h9002)}, pat(16'h9000), 8'h00);
		$display("refused start done");
	endtask

	// a reset in mid-instruction abandons the store and parks the bus
	task automatic testMidReset;
		start(CL_DIR_STORE, 16'hA000, 8'h5A);
		busCyc(16'hA000, 1'b1);
		@(posedge clk);
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk(busAddr, 16'hFFFF);
		chk({12'h000, instrDone, busRw, busDataOutEn, startAck}, 16'h0005);
		chk(operandWord, 16'h0000);
		chk({opcodeFirst, opcodeSecond}, 16'h0000);
		chk(wrAddr, {8'h00, pat(16'h6001)});
		start(CL_IMM8, 16'hB000, 8'h00);
		busCyc(16'hB000, 1'b1);
		busCyc(16'hB001, 1'b1);
		doneChk({8'h00, pat(16'hB001)}, pat(16'hB000), 8'h00);
		$display("mid-run reset done");
	endtask

	// the second request is raised in the done cycle and must start with no idle gap
	task automatic testBackToBack;
		start(CL_IMM8, 16'h7000, 8'h00);
		busCyc(16'h7000, 1'b1);
		busCyc(16'h7001, 1'b1);
		start(CL_IMM16_LOAD, 16'h7100, 8'h00);
		busCyc(16'h7100, 1'b1);
		busCyc(16'h7101, 1'b1);
		busCyc(16'h7102, 1'b1);
		doneChk({pat(16'h7101), pat(16'h7102)}, pat(16'h7100), 8'h00);
		$display("back to back done");
	endtask

	initial
	begin
		rst_b = 1'b0;
		startReq = 1'b0;
		startClass = CL_IMM8;
		opAddr = 16'h0000;
		accIn = 8'h00;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk(busAddr, 16'hFFFF);
		chk({13'h0000, busRw, busDataOutEn, startAck}, 16'h0005);
		testImm16Load();
		testImm16Arith();
		testPfx(CL_PFX_LOAD, 4);
		testPfx(CL_PFX_CMP, 5);
		testImm8();
		testDirect();
		testBackToBack();
		testRefused();
		testMidReset();
		endOfTest();
	end

	// cuts a hang short well before the run could grow long
	initial
	begin
		repeat (2000) @(posedge clk);
		miscompares++;
		endOfTest();
	end
endmodule
`default_nettype wire
